// >>> hw/cabl_pkg.sv
// package of shared constants and types for the execution unit
// assumes one 200 MHz core clock and an external decoder that supplies an op code
// How it works
// [RULE1] or-mask op: destination OR immediate, one cycle, updates Z N V, keeps C
// [RULE2] clear-mask op: destination AND inverted immediate, one cycle, updates Z N V
// [RULE3] test op: register AND itself, value kept, Z N V updated, one cycle
// [RULE4] increment op adds one in one cycle, Z N V only, C untouched
// [RULE5] zero op: register XOR itself gives zero, Z N V updated, one cycle
// [RULE6] pointer jump loads pc from Z pointer in two cycles, no flags
// [RULE7] pointer call pushes return address, pc from Z pointer, three cycles, no flags
// [RULE8] offset jump/call set pc to pc plus offset plus one; two/three cycles
// [RULE9] compare-skip-equal skips next instruction when registers equal; no flags
// [RULE10] compares subtract reg, immediate or reg plus carry; Z N V C H, one cycle
// [RULE11] register bit skips skip next instruction on bit clear or set
// [RULE12] io bit skips test an io register bit, skip on clear or set, no flags
// [RULE13] status bit branches add offset plus one on bit set or clear; 1/2 cycles
// [RULE14] equality branches test Z; same-or-higher on C clear, lower on C set
// [RULE15] signed branches test N xor V: ge when zero, lt when one
// [RULE16] half-carry branches taken on H set or clear; 1/2 cycles
// [RULE17] transfer-bit branches taken on T set or clear, same timing and arithmetic
// [RULE18] overflow branches taken on V set or clear; no flag changes
// [RULE19] irq branches taken on global interrupt enable set or clear
// [RULE20] post-increment load reads memory at X into destination, then X plus one; two cycles
// [RULE21] skips take one cycle with no skip, two over one word, three over two words

package cabl_pkg;

    // ----
    // widths
    // ----
    localparam int DATA_W = 8;
    localparam int PC_W   = 10;
    localparam int PTR_W  = 16;
    localparam int OFS_W  = 12;
    localparam int IDX_W  = 5;
    localparam int BIT_W  = 3;

    // ----
    // status flag positions and reset values
    // ----
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [DATA_W-1:0] STATUS_FLAGS_REGISTER_RST = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST   = 10'h000;
    localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;
    localparam logic [DATA_W-1:0] ONE_B    = 8'h01;
    localparam logic [DATA_W-1:0] MIN_NEG  = 8'h80;

    // ----
    // pc steps and extra wait cycles
    // ----
    localparam logic [PC_W-1:0] PC_STEP      = 10'h001;
    localparam logic [PC_W-1:0] PC_SKIP_ONE  = 10'h002;
    localparam logic [PC_W-1:0] PC_SKIP_TWO  = 10'h003;
    localparam logic [PTR_W-1:0] PTR_STEP    = 16'h0001;
    localparam logic [1:0] WAIT_ONE          = 2'h0;
    localparam logic [1:0] WAIT_TWO          = 2'h1;

    // ----
    // operation codes
    // ----
    typedef enum logic [5:0] {
        OP_OR_MASK    = 6'h00, OP_CLEAR_MASK = 6'h01, OP_TEST      = 6'h02,
        OP_INC        = 6'h03, OP_ZERO       = 6'h04, OP_PTR_JUMP  = 6'h05,
        OP_PTR_CALL   = 6'h06, OP_OFS_JUMP   = 6'h07, OP_OFS_CALL  = 6'h08,
        OP_CMP_SKIP   = 6'h09, OP_CMP        = 6'h0A, OP_CMPC      = 6'h0B,
        OP_CMPI       = 6'h0C, OP_SKIP_RB_C  = 6'h0D, OP_SKIP_RB_S = 6'h0E,
        OP_SKIP_IO_C  = 6'h0F, OP_SKIP_IO_S  = 6'h10, OP_BR_SB_S   = 6'h11,
        OP_BR_SB_C    = 6'h12, OP_BR_EQ      = 6'h13, OP_BR_NE     = 6'h14,
        OP_BR_SH      = 6'h15, OP_BR_LO      = 6'h16, OP_BR_GE     = 6'h17,
        OP_BR_LT      = 6'h18, OP_BR_HS      = 6'h19, OP_BR_HC     = 6'h1A,
        OP_BR_TS      = 6'h1B, OP_BR_TC      = 6'h1C, OP_BR_VS     = 6'h1D,
        OP_BR_VC      = 6'h1E, OP_BR_IE      = 6'h1F, OP_BR_ID     = 6'h20,
        OP_LOAD_INC   = 6'h21, OP_NOP        = 6'h3F
    } cabl_op_t;

    // ----
    // sequencer states, one-hot
    // ----
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_WAIT    = 4'b0010,
        ST_LOAD    = 4'b0100,
        ST_PUSH_HI = 4'b1000
    } cabl_state_t;

endpackage : cabl_pkg

// >>> hw/cabl_alu.sv
// combinational logic, increment and compare datapath with flag results
// assumes operands and flags are stable in the cycle the op is presented
`timescale 1ns/10ps

module cabl_alu
    import cabl_pkg::*;
(
    input  cabl_pkg::cabl_op_t           op,
    input  wire logic [cabl_pkg::DATA_W-1:0] opa,
    input  wire logic [cabl_pkg::DATA_W-1:0] opb,
    input  wire logic [cabl_pkg::DATA_W-1:0] flags_in,
    output logic      [cabl_pkg::DATA_W-1:0] result,
    output logic      [cabl_pkg::DATA_W-1:0] flags_out
);

    logic [DATA_W-1:0] diff;
    logic              cin;

    always_comb begin
        result    = opa;
        flags_out = flags_in;
        cin       = 1'b0;
        diff      = ZERO_B;
        case (op)
            // [RULE1] or with mask
            OP_OR_MASK: begin
                result = opa | opb;
            end
            // [RULE2] and with mask complement
            OP_CLEAR_MASK: begin
                result = opa & (ALL_ONES ^ opb);
            end
            // [RULE3] and with itself
            OP_TEST: begin
                result = opa & opa;
            end
            // [RULE4] add one
            OP_INC: begin
                result = opa + ONE_B;
            end
            // [RULE5] xor with itself
            OP_ZERO: begin
                result = opa ^ opa;
            end
            // [RULE10] subtract and flag
            OP_CMP, OP_CMPC, OP_CMPI: begin
                cin  = (op == OP_CMPC) ? flags_in[FLAG_C] : 1'b0;
                diff = opa - opb - {7'h00, cin};
                flags_out[FLAG_H] = (~opa[3] & opb[3]) | (opb[3] & diff[3]) | (diff[3] & ~opa[3]);
                flags_out[FLAG_C] = (~opa[7] & opb[7]) | (opb[7] & diff[7]) | (diff[7] & ~opa[7]);
                flags_out[FLAG_V] = (opa[7] & ~opb[7] & ~diff[7]) | (~opa[7] & opb[7] & diff[7]);
                flags_out[FLAG_N] = diff[7];
                flags_out[FLAG_Z] = (op == OP_CMPC) ? ((diff == ZERO_B) & flags_in[FLAG_Z])
                                                    : (diff == ZERO_B);
            end
            default: begin
                result = opa;
            end
        endcase
        // [RULE4] flags of mask, test, increment and zero ops
        if (op == OP_OR_MASK || op == OP_CLEAR_MASK || op == OP_TEST ||
            op == OP_INC || op == OP_ZERO) begin
            flags_out[FLAG_Z] = (result == ZERO_B);
            flags_out[FLAG_N] = result[7];
            flags_out[FLAG_V] = (op == OP_INC) ? (result == MIN_NEG) : 1'b0;
        end
    end

endmodule : cabl_alu

// >>> hw/cabl_exec.sv
// execution sequencer: pc, status flags, skips, branches, calls and pointer load
// assumes operands arrive with op_valid and data memory answers in the same cycle
`timescale 1ns/10ps

module cabl_exec
    import cabl_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        op_valid,
    input  cabl_pkg::cabl_op_t               op_code,
    output logic                             op_ready,
    input  wire logic [cabl_pkg::IDX_W-1:0]  dst_idx,
    input  wire logic [cabl_pkg::DATA_W-1:0] dst_val,
    input  wire logic [cabl_pkg::DATA_W-1:0] src_val,
    input  wire logic [cabl_pkg::DATA_W-1:0] imm_val,
    input  wire logic [cabl_pkg::DATA_W-1:0] io_val,
    input  wire logic [cabl_pkg::BIT_W-1:0]  bit_sel,
    input  wire logic [cabl_pkg::OFS_W-1:0]  offset,
    input  wire logic                        next_two_word,
    input  wire logic [cabl_pkg::PTR_W-1:0]  z_ptr,
    input  wire logic [cabl_pkg::PTR_W-1:0]  x_ptr,
    input  wire logic [cabl_pkg::DATA_W-1:0] mem_rdata,
    output logic                             mem_rd,
    output logic      [cabl_pkg::PTR_W-1:0]  mem_addr,
    output logic                             wr_en,
    output logic      [cabl_pkg::IDX_W-1:0]  wr_idx,
    output logic      [cabl_pkg::DATA_W-1:0] wr_data,
    output logic                             x_wr_en,
    output logic      [cabl_pkg::PTR_W-1:0]  x_wr_data,
    output logic                             stack_push,
    output logic      [cabl_pkg::DATA_W-1:0] stack_data,
    output logic      [cabl_pkg::PC_W-1:0]   pc,
    output logic      [cabl_pkg::DATA_W-1:0] status_flags_register
);

    // ----
    // helpers
    // ----
    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                   input logic [OFS_W-1:0] ofs);
        logic [OFS_W-1:0] sum;
        sum = {{(OFS_W-PC_W){1'b0}}, base} + ofs + {{(OFS_W-1){1'b0}}, 1'b1};
        return sum[PC_W-1:0];
    endfunction : rel_target

    function automatic logic branch_taken(input cabl_op_t o,
                                          input logic [DATA_W-1:0] f,
                                          input logic [BIT_W-1:0] s);
        logic t;
        t = 1'b0;
        case (o)
            // [RULE13] generic status bit
            OP_BR_SB_S: t = f[s];
            OP_BR_SB_C: t = ~f[s];
            // [RULE14] zero and carry tests
            OP_BR_EQ:   t = f[FLAG_Z];
            OP_BR_NE:   t = ~f[FLAG_Z];
            OP_BR_SH:   t = ~f[FLAG_C];
            OP_BR_LO:   t = f[FLAG_C];
            // [RULE15] negative xor overflow
            OP_BR_GE:   t = ~(f[FLAG_N] ^ f[FLAG_V]);
            OP_BR_LT:   t = f[FLAG_N] ^ f[FLAG_V];
            // [RULE16] half carry
            OP_BR_HS:   t = f[FLAG_H];
            OP_BR_HC:   t = ~f[FLAG_H];
            // [RULE17] transfer bit
            OP_BR_TS:   t = f[FLAG_T];
            OP_BR_TC:   t = ~f[FLAG_T];
            // [RULE18] overflow
            OP_BR_VS:   t = f[FLAG_V];
            OP_BR_VC:   t = ~f[FLAG_V];
            // [RULE19] interrupt enable
            OP_BR_IE:   t = f[FLAG_I];
            OP_BR_ID:   t = ~f[FLAG_I];
            default:    t = 1'b0;
        endcase
        return t;
    endfunction : branch_taken

    function automatic logic is_branch(input cabl_op_t o);
        return (o >= OP_BR_SB_S) && (o <= OP_BR_ID);
    endfunction : is_branch

    // ----
    // state
    // ----
    cabl_state_t       state_q,  state_d;
    logic [1:0]        wait_q,   wait_d;
    logic [PC_W-1:0]   pc_q,     pc_d;
    logic [DATA_W-1:0] status_flags_register_q,   status_flags_register_d;
    logic              mem_rd_q, mem_rd_d;
    logic [PTR_W-1:0]  addr_q,   addr_d;
    logic              wr_en_q,  wr_en_d;
    logic [IDX_W-1:0]  wr_idx_q, wr_idx_d;
    logic [DATA_W-1:0] wr_dat_q, wr_dat_d;
    logic              xwe_q,    xwe_d;
    logic [PTR_W-1:0]  xdat_q,   xdat_d;
    logic              push_q,   push_d;
    logic [DATA_W-1:0] sdat_q,   sdat_d;
    logic [DATA_W-1:0] ret_hi_q, ret_hi_d;

    logic [DATA_W-1:0] alu_res;
    logic [DATA_W-1:0] alu_flags;
    logic [DATA_W-1:0] alu_b;
    logic [PC_W-1:0]   ret_addr;
    logic              do_skip;

    assign alu_b = (op_code == OP_CMP || op_code == OP_CMPC) ? src_val : imm_val;

    cabl_alu u_alu (
        .op        (op_code),
        .opa       (dst_val),
        .opb       (alu_b),
        .flags_in  (status_flags_register_q),
        .result    (alu_res),
        .flags_out (alu_flags)
    );

    // ----
    // skip decision
    // ----
    always_comb begin
        case (op_code)
            // [RULE9] equal registers
            OP_CMP_SKIP:  do_skip = (dst_val == src_val);
            // [RULE11] register bit
            OP_SKIP_RB_C: do_skip = ~src_val[bit_sel];
            OP_SKIP_RB_S: do_skip = src_val[bit_sel];
            // [RULE12] io register bit
            OP_SKIP_IO_C: do_skip = ~io_val[bit_sel];
            OP_SKIP_IO_S: do_skip = io_val[bit_sel];
            default:      do_skip = 1'b0;
        endcase
    end

    assign ret_addr = pc_q + PC_STEP;
    assign op_ready = (state_q == ST_IDLE);

    // ----
    // next state
    // ----
    always_comb begin
        state_d  = state_q;
        wait_d   = wait_q;
        pc_d     = pc_q;
        status_flags_register_d   = status_flags_register_q;
        mem_rd_d = 1'b0;
        addr_d   = addr_q;
        wr_en_d  = 1'b0;
        wr_idx_d = wr_idx_q;
        wr_dat_d = wr_dat_q;
        xwe_d    = 1'b0;
        xdat_d   = xdat_q;
        push_d   = 1'b0;
        sdat_d   = sdat_q;
        ret_hi_d = ret_hi_q;
        case (state_q)
            ST_IDLE: begin
                if (op_valid) begin
                    pc_d = ret_addr;
                    case (op_code)
                        // [RULE1] one-cycle register ops
                        OP_OR_MASK, OP_CLEAR_MASK, OP_TEST, OP_INC, OP_ZERO: begin
                            wr_en_d  = 1'b1;
                            wr_idx_d = dst_idx;
                            wr_dat_d = alu_res;
                            status_flags_register_d   = alu_flags;
                        end
                        // [RULE10] flags only
                        OP_CMP, OP_CMPC, OP_CMPI: begin
                            status_flags_register_d = alu_flags;
                        end
                        // [RULE21] skip lengths
                        OP_CMP_SKIP, OP_SKIP_RB_C, OP_SKIP_RB_S,
                        OP_SKIP_IO_C, OP_SKIP_IO_S: begin
                            if (do_skip) begin
                                pc_d    = next_two_word ? pc_q + PC_SKIP_TWO
                                                        : pc_q + PC_SKIP_ONE;
                                wait_d  = next_two_word ? WAIT_TWO : WAIT_ONE;
                                state_d = ST_WAIT;
                            end
                        end
                        // [RULE8] offset jump
                        OP_OFS_JUMP: begin
                            pc_d    = rel_target(pc_q, offset);
                            wait_d  = WAIT_ONE;
                            state_d = ST_WAIT;
                        end
                        // [RULE6] pointer jump
                        OP_PTR_JUMP: begin
                            pc_d    = z_ptr[PC_W-1:0];
                            wait_d  = WAIT_ONE;
                            state_d = ST_WAIT;
                        end
                        // [RULE7] calls push low byte first
                        OP_PTR_CALL, OP_OFS_CALL: begin
                            pc_d     = (op_code == OP_PTR_CALL) ? z_ptr[PC_W-1:0]
                                                                : rel_target(pc_q, offset);
                            push_d   = 1'b1;
                            sdat_d   = ret_addr[DATA_W-1:0];
                            ret_hi_d = {{(2*DATA_W-PC_W){1'b0}}, ret_addr[PC_W-1:DATA_W]};
                            state_d  = ST_PUSH_HI;
                        end
                        // [RULE20] read at pointer
                        OP_LOAD_INC: begin
                            mem_rd_d = 1'b1;
                            addr_d   = x_ptr;
                            wr_idx_d = dst_idx;
                            state_d  = ST_LOAD;
                        end
                        default: begin
                            if (is_branch(op_code) && branch_taken(op_code, status_flags_register_q, bit_sel)) begin
                                pc_d    = rel_target(pc_q, offset);
                                wait_d  = WAIT_ONE;
                                state_d = ST_WAIT;
                            end
                        end
                    endcase
                end
            end
            // [RULE20] capture and post-increment
            ST_LOAD: begin
                wr_en_d  = 1'b1;
                wr_dat_d = mem_rdata;
                xwe_d    = 1'b1;
                xdat_d   = addr_q + PTR_STEP;
                state_d  = ST_IDLE;
            end
            // [RULE7] high byte then one idle cycle
            ST_PUSH_HI: begin
                push_d  = 1'b1;
                sdat_d  = ret_hi_q;
                wait_d  = WAIT_ONE;
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (wait_q == WAIT_ONE) begin
                    state_d = ST_IDLE;
                end else begin
                    wait_d = wait_q - 2'h1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ----
    // registers
    // ----
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= ST_IDLE;
            wait_q   <= WAIT_ONE;
            pc_q     <= PC_RST;
            status_flags_register_q   <= STATUS_FLAGS_REGISTER_RST;
            mem_rd_q <= 1'b0;
            addr_q   <= '0;
            wr_en_q  <= 1'b0;
            wr_idx_q <= '0;
            wr_dat_q <= ZERO_B;
            xwe_q    <= 1'b0;
            xdat_q   <= '0;
            push_q   <= 1'b0;
            sdat_q   <= ZERO_B;
            ret_hi_q <= ZERO_B;
        end else begin
            state_q  <= state_d;
            wait_q   <= wait_d;
            pc_q     <= pc_d;
            status_flags_register_q   <= status_flags_register_d;
            mem_rd_q <= mem_rd_d;
            addr_q   <= addr_d;
            wr_en_q  <= wr_en_d;
            wr_idx_q <= wr_idx_d;
            wr_dat_q <= wr_dat_d;
            xwe_q    <= xwe_d;
            xdat_q   <= xdat_d;
            push_q   <= push_d;
            sdat_q   <= sdat_d;
            ret_hi_q <= ret_hi_d;
        end
    end

    assign mem_rd                = mem_rd_q;
    assign mem_addr              = addr_q;
    assign wr_en                 = wr_en_q;
    assign wr_idx                = wr_idx_q;
    assign wr_data               = wr_dat_q;
    assign x_wr_en               = xwe_q;
    assign x_wr_data             = xdat_q;
    assign stack_push            = push_q;
    assign stack_data            = sdat_q;
    assign pc                    = pc_q;
    assign status_flags_register = status_flags_register_q;

endmodule : cabl_exec

// >>> dv/cabl_exec_properties.sv
// port checker for the execution sequencer
// assumes a bind onto cabl_exec, one clock domain
`timescale 1ns/10ps

module cabl_exec_properties
    import cabl_pkg::*;
(
    input wire logic                         sys_clk,
    input wire logic                         sys_rst,
    input wire logic                         op_valid,
    input cabl_pkg::cabl_op_t                op_code,
    input wire logic                         op_ready,
    input wire logic [cabl_pkg::DATA_W-1:0]  dst_val,
    input wire logic [cabl_pkg::DATA_W-1:0]  src_val,
    input wire logic [cabl_pkg::DATA_W-1:0]  imm_val,
    input wire logic [cabl_pkg::OFS_W-1:0]   offset,
    input wire logic                         next_two_word,
    input wire logic [cabl_pkg::PTR_W-1:0]   z_ptr,
    input wire logic [cabl_pkg::PTR_W-1:0]   x_ptr,
    input wire logic                         mem_rd,
    input wire logic [cabl_pkg::PTR_W-1:0]   mem_addr,
    input wire logic                         wr_en,
    input wire logic [cabl_pkg::DATA_W-1:0]  wr_data,
    input wire logic                         x_wr_en,
    input wire logic [cabl_pkg::PTR_W-1:0]   x_wr_data,
    input wire logic                         stack_push,
    input wire logic [cabl_pkg::PC_W-1:0]    pc,
    input wire logic [cabl_pkg::DATA_W-1:0]  status_flags_register
);
    logic acc;
    assign acc = op_valid && op_ready;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----
    // sequences
    // ----
    sequence s_push;
        stack_push && !op_ready;
    endsequence
    sequence s_load;
        mem_rd && mem_addr == $past(x_ptr) ##1
            wr_en && x_wr_en && x_wr_data == $past(x_ptr, 2) + 16'h0001;
    endsequence
    // ----
    // assertions
    // ----
    AST_OR_MASK: assert property (acc && op_code == OP_OR_MASK |=>
        wr_en && wr_data == ($past(dst_val) | $past(imm_val)) &&
        $stable(status_flags_register[FLAG_C])) else $error("or mask wrong");
    AST_CLR_MASK: assert property (acc && op_code == OP_CLEAR_MASK |=>
        wr_data == ($past(dst_val) & ~$past(imm_val))) else $error("clear mask wrong");
    AST_INC: assert property (acc && op_code == OP_INC |=>
        wr_en && op_ready && wr_data == $past(dst_val) + 8'h01) else $error("inc wrong");
    AST_ZERO: assert property (acc && op_code == OP_ZERO |=>
        wr_data == 8'h00 && status_flags_register[FLAG_Z]) else $error("zero op wrong");
    AST_PJUMP: assert property (acc && op_code == OP_PTR_JUMP |=>
        pc == PC_W'($past(z_ptr)) && !op_ready ##1 op_ready) else $error("ptr jump wrong");
    AST_PCALL: assert property (acc && op_code == OP_PTR_CALL |=>
        s_push ##1 s_push ##1 op_ready && !stack_push) else $error("ptr call wrong");
    AST_OJUMP: assert property (acc && op_code == OP_OFS_JUMP |=>
        pc == $past(pc) + PC_W'($past(offset)) + 10'h001) else $error("ofs jump wrong");
    AST_SKIP: assert property (acc && op_code == OP_CMP_SKIP && dst_val == src_val
        && !next_two_word |=> pc == $past(pc) + 10'h002) else $error("skip wrong");
    AST_BR_FLAGS: assert property (acc && op_code inside {[OP_BR_SB_S:OP_BR_ID]}
        |=> $stable(status_flags_register)) else $error("branch changed flags");
    AST_LOAD: assert property (acc && op_code == OP_LOAD_INC |=>
        s_load) else $error("load wrong");
endmodule : cabl_exec_properties

bind cabl_exec cabl_exec_properties u_chk (.sys_clk, .sys_rst, .op_valid, .op_code,
    .op_ready, .dst_val, .src_val, .imm_val, .offset, .next_two_word, .z_ptr, .x_ptr,
    .mem_rd, .mem_addr, .wr_en, .wr_data, .x_wr_en, .x_wr_data, .stack_push, .pc,
    .status_flags_register);

// >>> dv/tb_cpu_alu_branch_load_execute.sv
// self-checking bench for the execution sequencer
// assumes cabl_pkg and cabl_exec compiled first
`timescale 1ns/10ps

module tb_cpu_alu_branch_load_execute;
    import cabl_pkg::*;
    logic        sys_clk = 0, sys_rst = 1, op_valid = 0, next_two_word = 0;
    cabl_op_t    op_code = OP_NOP;
    logic [4:0]  dst_idx = 5'h03, wr_idx;
    logic [7:0]  dst_val = 0, src_val = 0, imm_val = 0, io_val = 0, mem_rdata = 8'hA5;
    logic [2:0]  bit_sel = 0;
    logic [11:0] offset = 0;
    logic [15:0] z_ptr = 0, x_ptr = 0, mem_addr, x_wr_data, sq;
    logic        op_ready, mem_rd, wr_en, x_wr_en, stack_push, wseen;
    logic [7:0]  wr_data, stack_data, flags, wd, f0;
    logic [9:0]  pc, p0, ret;
    int          n_fail = 0, check_count = 0, cyc, pushes;

    cabl_exec dut (.sys_clk, .sys_rst, .op_valid, .op_code, .op_ready, .dst_idx, .dst_val,
        .src_val, .imm_val, .io_val, .bit_sel, .offset, .next_two_word, .z_ptr, .x_ptr,
        .mem_rdata, .mem_rd, .mem_addr, .wr_en, .wr_idx, .wr_data, .x_wr_en, .x_wr_data,
        .stack_push, .stack_data, .pc, .status_flags_register(flags));

    always #2.5 sys_clk = ~sys_clk;
    // ----
    // helpers
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d failures=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic grab();
        if (wr_en === 1'b1) begin
            wseen = 1;
            wd = wr_data;
        end
        if (stack_push === 1'b1) begin
            pushes++;
            sq = {sq[7:0], stack_data};
        end
    endtask : grab

    task automatic issue(input cabl_op_t o);
        @(negedge sys_clk);
        op_valid = 1;
        op_code = o;
        p0 = pc;
        f0 = flags;
        @(negedge sys_clk);
        op_valid = 0;
        cyc = 1;
        wseen = 0;
        pushes = 0;
        grab();
        while (op_ready !== 1'b1 && cyc < 8) begin
            @(negedge sys_clk);
            cyc++;
            grab();
        end
    endtask : issue
    // ----
    // scenarios
    // ----
    task automatic t_logic();
        cabl_op_t   ops[5] = '{OP_OR_MASK, OP_CLEAR_MASK, OP_TEST, OP_INC, OP_ZERO};
        logic [7:0] dv[5] = '{8'h80, 8'hF0, 8'h80, 8'h7F, 8'h5A};
        logic [7:0] im[5] = '{8'h01, 8'hF0, 8'h00, 8'h00, 8'h00};
        logic [7:0] ex[5] = '{8'h81, 8'h00, 8'h80, 8'h80, 8'h00};
        logic [3:0] fx[5] = '{4'h5, 4'h3, 4'h5, 4'hD, 4'h3};
        src_val = 8'h01;
        dst_val = 8'h00;
        issue(OP_CMP);
        for (int i = 0; i < 5; i++) begin
            dst_val = dv[i];
            imm_val = im[i];
            issue(ops[i]);
            chk(16'({wseen, wd}), 16'({1'b1, ex[i]}));
            chk(16'(flags[3:0]), 16'(fx[i]));
            chk(16'(cyc), 16'h0001);
        end
        $display("logic ops done");
    endtask : t_logic

    task automatic t_cmp();
        cabl_op_t   ops[5] = '{OP_CMP, OP_CMPC, OP_CMPI, OP_CMP, OP_CMPC};
        logic [7:0] dv[5] = '{8'h05, 8'h05, 8'h80, 8'h00, 8'h01};
        logic [7:0] sv[5] = '{8'h05, 8'h05, 8'h01, 8'h01, 8'h00};
        logic [7:0] fx[5] = '{8'h02, 8'h02, 8'h28, 8'h25, 8'h00};
        for (int i = 0; i < 5; i++) begin
            dst_val = dv[i];
            src_val = sv[i];
            imm_val = sv[i];
            issue(ops[i]);
            chk(16'(flags & 8'h2F), 16'(fx[i]));
            chk(16'(wseen), 16'h0000);
        end
        $display("compares done");
    endtask : t_cmp

    task automatic t_branch();
        dst_val = 8'h80;
        imm_val = 8'h01;
        issue(OP_CMPI);
        bit_sel = 3'h3;
        offset = 12'hFFD;
        for (int i = 0; i < 16; i++) begin
            issue(cabl_op_t'(6'h11 + i));
            chk(16'(pc), 16'(16'h9999 >> i & 1 ? p0 - 10'h002 : p0 + 10'h001));
            chk(16'(cyc), 16'(16'h9999 >> i & 1 ? 2 : 1));
            chk(16'(flags), 16'(f0));
        end
        $display("branches done");
    endtask : t_branch

    task automatic t_flow();
        offset = 12'h005;
        issue(OP_OFS_JUMP);
        chk(16'(pc), 16'(p0 + 10'h006));
        chk(16'(cyc), 16'h0002);
        offset = 12'hFFE;
        issue(OP_OFS_CALL);
        ret = p0 + 10'h001;
        chk(16'(pc), 16'(p0 - 10'h001));
        chk(sq, {ret[7:0], 6'h00, ret[9:8]});
        chk(16'(cyc), 16'h0003);
        z_ptr = 16'h1234;
        issue(OP_PTR_JUMP);
        chk(16'(pc), 16'h0234);
        chk(16'(cyc), 16'h0002);
        z_ptr = 16'h0155;
        issue(OP_PTR_CALL);
        ret = p0 + 10'h001;
        chk(16'(pc), 16'h0155);
        chk(sq, {ret[7:0], 6'h00, ret[9:8]});
        chk(16'({pushes[3:0], 4'(cyc), flags}), 16'({4'h2, 4'h3, f0}));
        $display("jumps and calls done");
    endtask : t_flow

    task automatic t_skip();
        cabl_op_t   ops[6] = '{OP_CMP_SKIP, OP_CMP_SKIP, OP_SKIP_RB_C, OP_SKIP_RB_S,
                               OP_SKIP_IO_C, OP_SKIP_IO_S};
        logic [7:0] v[6] = '{8'h33, 8'h34, 8'hF7, 8'hF7, 8'hF7, 8'h08};
        logic [9:0] st[6] = '{10'h002, 10'h001, 10'h003, 10'h001, 10'h002, 10'h003};
        dst_val = 8'h33;
        bit_sel = 3'h3;
        for (int i = 0; i < 6; i++) begin
            src_val = v[i];
            io_val = v[i];
            next_two_word = 1'(6'b101110 >> i);
            issue(ops[i]);
            chk(16'(pc), 16'(p0 + st[i]));
            chk(16'(cyc), 16'(st[i]));
            chk(16'(flags), 16'(f0));
        end
        $display("skips done");
    endtask : t_skip

    task automatic t_load();
        x_ptr = 16'hFFFF;
        dst_idx = 5'h07;
        issue(OP_LOAD_INC);
        chk(16'({wd, 3'h0, wr_idx}), 16'hA507);
        chk(mem_addr, 16'hFFFF);
        chk(x_wr_data, 16'h0000);
        chk(16'(cyc), 16'h0002);
        $display("load done");
    endtask : t_load
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        repeat (10) @(negedge sys_clk);
        sys_rst = 0;
        chk(16'({op_ready, 5'h00, pc}), 16'h8000);
        chk(16'(flags), 16'h0000);
        t_logic();
        t_cmp();
        t_branch();
        t_flow();
        t_skip();
        t_load();
        conclude();
    end

    initial begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule : tb_cpu_alu_branch_load_execute
